// *** rtl/twu_map.svh ***
// register indices, key values, reset values and timing counts
`ifndef TWU_MAP_SVH
`define TWU_MAP_SVH
// register indices, byte address is four times the index
`define TWU_IDX_KEY 8'hc7
`define TWU_IDX_STAT 8'hc8
`define TWU_IDX_PMC 8'ha3
`define TWU_IDX_CHIP 8'h9f
`define TWU_IDX_ISP 8'ha4
`define TWU_IDX_BOOT 8'h9c
`define TWU_IDX_WD0 8'hd8
`define TWU_IDX_WD1 8'hab
`define TWU_NO_SLOT 3'd7
// key values
`define TWU_KEY_OPEN 8'haa
`define TWU_KEY_CONF 8'h55
`define TWU_KEY_RST 8'hff
// status bit positions
`define TWU_STAT_OPEN 0
`define TWU_STAT_WAIT 1
`define TWU_STAT_DROP 2
// reset value of protected registers
`define TWU_PROT_RST 8'h00
// timing, in machine cycles
`define TWU_GAP_MC 2'd3
`define TWU_WIN_MC 2'd3
// core clocks per machine cycle
`define TWU_MC_CLKS 4
`endif

// *** rtl/twu_pkg.sv ***
// types of the timed write unlock gate
package twu_pkg;
    typedef logic [7:0] twu_byte_t;
    typedef enum logic [1:0] {
        TWU_IDLE = 2'b01,
        TWU_WAIT = 2'b10
    } twu_key_e;
    typedef struct packed {
        logic setup;
        logic acc;
        logic wr;
        logic ok;
        logic [7:0] idx;
        logic [7:0] wdat;
    } twu_req_s;
endpackage

// *** rtl/twu_top.sv ***
// timed write unlock gate with its six protected registers, apb slave
`timescale 1ns/100ps
`include "twu_map.svh"

module twu_top
    import twu_pkg::*;
#(
    parameter int unsigned MC_CLKS = `TWU_MC_CLKS,
    parameter int unsigned ADDR_W = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // protected register contents
    output logic [5:0][7:0] prot_regs
);
    localparam int DIV_W = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;

    function automatic logic [2:0] slot_of(input logic [7:0] idx);
        case (idx)
            `TWU_IDX_PMC: slot_of = 3'd0;
            `TWU_IDX_CHIP: slot_of = 3'd1;
            `TWU_IDX_ISP: slot_of = 3'd2;
            `TWU_IDX_BOOT: slot_of = 3'd3;
            `TWU_IDX_WD0: slot_of = 3'd4;
            `TWU_IDX_WD1: slot_of = 3'd5;
            default: slot_of = `TWU_NO_SLOT;
        endcase
    endfunction

    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;
    twu_key_e st_q, st_d;
    logic [1:0] gap_q, gap_d;
    logic [1:0] win_q, win_d;
    logic [5:0][7:0] prot_q, prot_d;
    logic drop_q, drop_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    twu_req_s rq;
    logic wr_key, key_ok55, prot_wr, stat_wr, win_open;
    logic [2:0] wr_slot, rd_slot;
    twu_byte_t rd_byte;

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign prot_regs = prot_q;

    // machine cycle tick
    always_comb begin
        div_d = div_q + 1'b1;
        tick_d = 1'b0;
        if (div_q == DIV_W'(MC_CLKS - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    // request decode
    always_comb begin
        rq.setup = psel & ~penable;
        rq.acc = psel & penable & pready_q;
        rq.wr = pwrite;
        rq.ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
        rq.idx = paddr[9:2];
        rq.wdat = pwdata[7:0];
    end

    assign wr_slot = slot_of(rq.idx);
    assign rd_slot = slot_of(rq.idx);
    assign wr_key = rq.acc & rq.wr & rq.ok & (rq.idx == `TWU_IDX_KEY);
    assign stat_wr = rq.acc & rq.wr & rq.ok & (rq.idx == `TWU_IDX_STAT);
    assign prot_wr = rq.acc & rq.wr & rq.ok & (wr_slot != `TWU_NO_SLOT);
    assign win_open = (win_q != 2'd0);
    assign key_ok55 = wr_key && (rq.wdat == `TWU_KEY_CONF) && (st_q == TWU_WAIT) && (gap_q != 2'd0);

    // key sequence and window
    always_comb begin
        st_d = st_q;
        gap_d = gap_q;
        win_d = win_q;
        if (tick_q && gap_q != 2'd0) begin
            gap_d = gap_q - 2'd1;
        end
        if (tick_q && win_open) begin
            win_d = win_q - 2'd1;
        end
        if (st_q == TWU_WAIT && gap_q == 2'd0) begin
            st_d = TWU_IDLE;
        end
        if (wr_key) begin
            if (rq.wdat == `TWU_KEY_OPEN) begin
                st_d = TWU_WAIT;
                gap_d = `TWU_GAP_MC;
            end else if (key_ok55) begin
                st_d = TWU_IDLE;
                gap_d = 2'd0;
                win_d = `TWU_WIN_MC;
            end else begin
                st_d = TWU_IDLE;
                gap_d = 2'd0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_q <= TWU_IDLE;
            gap_q <= 2'd0;
            win_q <= 2'd0;
        end else begin
            st_q <= st_d;
            gap_q <= gap_d;
            win_q <= win_d;
        end
    end

    // protected registers and dropped-write flag
    always_comb begin
        prot_d = prot_q;
        drop_d = drop_q;
        if (stat_wr && rq.wdat[`TWU_STAT_DROP]) begin
            drop_d = 1'b0;
        end
        for (int i = 0; i < 6; i++) begin
            if (prot_wr && wr_slot == 3'(i) && win_open) begin
                prot_d[i] = rq.wdat;
            end
        end
        if (prot_wr && !win_open) begin
            drop_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prot_q <= {6{`TWU_PROT_RST}};
            drop_q <= 1'b0;
        end else begin
            prot_q <= prot_d;
            drop_q <= drop_d;
        end
    end

    // apb answer, one wait-free access phase
    always_comb begin
        rd_byte = 8'h00;
        if (rd_slot != `TWU_NO_SLOT) begin
            rd_byte = prot_q[rd_slot];
        end else if (rq.idx == `TWU_IDX_STAT) begin
            rd_byte[`TWU_STAT_OPEN] = win_open;
            rd_byte[`TWU_STAT_WAIT] = (st_q == TWU_WAIT);
            rd_byte[`TWU_STAT_DROP] = drop_q;
        end
    end

    always_comb begin
        pready_d = rq.setup;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (rq.setup) begin
            pslverr_d = !(rq.ok && (rd_slot != `TWU_NO_SLOT || rq.idx == `TWU_IDX_KEY ||
                rq.idx == `TWU_IDX_STAT));
            if (!rq.wr && rq.ok) begin
                prdata_d = {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ticks since the window last opened, for checking only
    logic [2:0] tk_q, tk_d;
    always_comb begin
        tk_d = tk_q;
        if (key_ok55) begin
            tk_d = 3'd0;
        end else if (tick_q && tk_q != 3'd7) begin
            tk_d = tk_q + 3'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tk_q <= 3'd7;
        end else begin
            tk_q <= tk_d;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence key_open_s;
        wr_key && rq.wdat == `TWU_KEY_OPEN;
    endsequence

    sequence key_conf_s;
        key_ok55;
    endsequence

    sequence closed_wr_s;
        prot_wr && !win_open;
    endsequence

    key_gap_a: assert property (key_open_s |=> st_q == TWU_WAIT && gap_q == 2'd3)
        else $error("0xaa key did not start the gap count");

    win_open_a: assert property (key_conf_s |=> win_q == 2'd3 ##0 win_open [*1])
        else $error("0x55 key did not open the window");

    win_count_a: assert property (tick_q && win_open && !key_ok55 |=> win_q == $past(win_q) - 2'd1)
        else $error("window count did not step on the tick");

    drop_write_a: assert property (closed_wr_s |=> $stable(prot_q) && drop_q)
        else $error("protected write landed while window closed");

    read_back_a: assert property (rq.setup && !rq.wr && rq.ok && rd_slot != 3'd7 |=>
        prdata_q[7:0] == $past(rd_byte) && pready_q && !pslverr_q)
        else $error("protected register did not read back");

    late_key_a: assert property (wr_key && rq.wdat == 8'h55 && !key_ok55 && !win_open |=> !win_open)
        else $error("late 0x55 opened the window");

    map_err_a: assert property (rq.setup && !(rq.ok && (rd_slot != 3'd7 || rq.idx == 8'hc7 ||
        rq.idx == 8'hc8)) |=> pslverr_q && pready_q)
        else $error("unmapped address answered without error");

    win_len_a: assert property (win_open == (tk_q < 3'd3))
        else $error("window not open for exactly three ticks");

    key_read_a: assert property (rq.setup && !rq.wr && rq.ok && rq.idx == 8'hc7 |=>
        prdata_q == 32'h0 && !pslverr_q)
        else $error("write-only key register read nonzero");

    key_abort_a: assert property (wr_key && rq.wdat != 8'haa && rq.wdat != 8'h55 |=>
        st_q == TWU_IDLE && !$rose(win_open))
        else $error("stray key value did not abandon sequence");

    rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> st_q == TWU_IDLE && win_q == 2'd0)
        else $error("reset left a sequence or window pending");

    stale_wr_a: assert property (prot_wr && tk_q >= 3'd3 |=> $stable(prot_q))
        else $error("write outside the window changed a register");

    prot_hold_a: assert property (!prot_wr |=> $stable(prot_q))
        else $error("protected register changed without a protected write");

    gap_end_a: assert property (st_q == TWU_WAIT && gap_q == 2'd0 && !wr_key |=> st_q == TWU_IDLE)
        else $error("expired key wait did not return to idle");

    gap_step_a: assert property (tick_q && st_q == TWU_WAIT && gap_q != 2'd0 && !wr_key |=>
        gap_q == $past(gap_q) - 2'd1)
        else $error("key gap count did not step on the tick");

    win_quiet_a: assert property (!key_ok55 && !win_open |=> !win_open)
        else $error("window opened without an accepted 0x55 key");

    drop_clear_a: assert property (stat_wr && rq.wdat[`TWU_STAT_DROP] |=> !drop_q)
        else $error("dropped-write flag did not clear");
endmodule

// *** tb/twu_cpu_model.sv ***
// processor core model driving the apb side of the unlock gate
`timescale 1ns/100ps
`include "twu_map.svh"
module twu_cpu_model (
    // clock
    input wire logic core_clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // released address and data lines show the inverse of their last value
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        repeat (n) @(posedge core_clk);
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, input int gap,
                        output logic [31:0] rd, output logic err);
        if (gap > 0) idle(gap);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask

    // 0xaa key, then second key value k2 after g1 idle clocks
    task automatic unlock(input int g1, input logic [7:0] k2);
        logic [31:0] rd;
        logic err;
        xfer(1'b1, `TWU_IDX_KEY, `TWU_KEY_OPEN, 0, rd, err);
        xfer(1'b1, `TWU_IDX_KEY, k2, g1, rd, err);
    endtask
endmodule

// *** tb/tb_timed_write_unlock.sv ***
// self-checking bench for the timed write unlock gate
`timescale 1ns/100ps
`include "twu_map.svh"
module tb_timed_write_unlock;
    import twu_pkg::*;
    typedef struct {int slot; int g1; int g2; twu_byte_t k2; logic land;} twu_row_s;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0][7:0] prot_regs;
    int errors = 0;
    int n_tests = 0;
    twu_byte_t mdl [6];
    twu_byte_t slot_idx [6] = '{`TWU_IDX_PMC, `TWU_IDX_CHIP, `TWU_IDX_ISP, `TWU_IDX_BOOT, `TWU_IDX_WD0,
                                `TWU_IDX_WD1};
    twu_row_s rows [10] = '{
        '{0, 0, 0, `TWU_KEY_CONF, 1'b1},
        '{1, 0, 6, `TWU_KEY_CONF, 1'b1},
        '{2, 0, 12, `TWU_KEY_CONF, 1'b0},
        '{3, 12, 0, `TWU_KEY_CONF, 1'b0},
        '{4, 0, 0, `TWU_KEY_CONF, 1'b1},
        '{5, 0, 0, `TWU_KEY_CONF, 1'b1},
        '{0, 0, 0, 8'h54, 1'b0},
        '{3, 0, 0, `TWU_KEY_OPEN, 1'b0},
        '{3, 0, 0, `TWU_KEY_CONF, 1'b1},
        '{2, 0, 0, `TWU_KEY_CONF, 1'b1}
    };

    initial forever #4 core_clk = ~core_clk;

    twu_top #(.MC_CLKS(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .prot_regs(prot_regs));
    twu_cpu_model cpu_u (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // read every protected register, compare it and the port with the model
    task automatic verify;
        for (int s = 0; s < 6; s++) begin
            cpu_u.xfer(1'b0, slot_idx[s], 8'h00, 1, rd, err);
            check(rd, {24'h000000, mdl[s]});
            check({24'h000000, prot_regs[s]}, {24'h000000, mdl[s]});
        end
    endtask

    task automatic pw(input int s, input twu_byte_t d, input int g, input logic land);
        cpu_u.xfer(1'b1, slot_idx[s], d, g, rd, err);
        if (land) mdl[s] = d;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        report_and_stop;
    end

    initial begin
        mdl = '{default: `TWU_PROT_RST};
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        verify;
        cpu_u.xfer(1'b0, `TWU_IDX_KEY, 8'h00, 1, rd, err);
        check(rd, 32'h00000000);
        check({31'h0, err}, 32'h00000000);
        cpu_u.xfer(1'b0, 8'h10, 8'h00, 1, rd, err);
        check({31'h0, err}, 32'h00000001);
        pw(3, 8'h5a, 1, 1'b0);
        // sticky dropped-write flag, then its clear
        cpu_u.xfer(1'b0, `TWU_IDX_STAT, 8'h00, 1, rd, err);
        check(rd, 32'h1 << `TWU_STAT_DROP);
        cpu_u.xfer(1'b1, `TWU_IDX_STAT, 8'h1 << `TWU_STAT_DROP, 1, rd, err);
        cpu_u.xfer(1'b0, `TWU_IDX_STAT, 8'h00, 1, rd, err);
        check(rd, 32'h00000000);
        // first key alone leaves the wait pending
        cpu_u.unlock(0, `TWU_KEY_OPEN);
        cpu_u.xfer(1'b0, `TWU_IDX_STAT, 8'h00, 0, rd, err);
        check(rd, 32'h1 << `TWU_STAT_WAIT);
        cpu_u.idle(16);
        foreach (rows[i]) begin
            cpu_u.unlock(rows[i].g1, rows[i].k2);
            pw(rows[i].slot, {4'(i), 4'ha}, rows[i].g2, rows[i].land);
            cpu_u.idle(16);
            verify;
        end
        // two protected writes, the second three machine cycles after the first
        cpu_u.unlock(0, `TWU_KEY_CONF);
        pw(1, 8'h77, 0, 1'b1);
        pw(2, 8'h88, 10, 1'b0);
        cpu_u.idle(16);
        verify;
        // reset with the window open
        cpu_u.unlock(0, `TWU_KEY_CONF);
        cpu_u.xfer(1'b0, `TWU_IDX_STAT, 8'h00, 0, rd, err);
        check(rd & 32'h00000003, 32'h1 << `TWU_STAT_OPEN);
        cpu_u.idle(1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        mdl = '{default: `TWU_PROT_RST};
        pw(0, 8'h99, 1, 1'b0);
        cpu_u.xfer(1'b0, `TWU_IDX_STAT, 8'h00, 0, rd, err);
        check(rd, 32'h1 << `TWU_STAT_DROP);
        cpu_u.idle(16);
        verify;
        report_and_stop;
    end
endmodule
